// ===== design/ctp_pkg.sv
package ctp_pkg;

    // Frame and source geometry
    localparam logic [3:0] BITS_PER_FRAME = 4'h8;
    localparam logic [3:0] LAST_BIT_CNT = 4'h7;
    localparam int NSRC = 8;

    // Event source slots, scanned in circular order
    localparam logic [2:0] SRC_FAR_END = 3'h0;
    localparam logic [2:0] SRC_FRAME_LOSS = 3'h1;
    localparam logic [2:0] SRC_ACT_DONE = 3'h2;
    localparam logic [2:0] SRC_DEACT = 3'h3;
    localparam logic [2:0] SRC_MSG_END = 3'h4;
    localparam logic [2:0] SRC_SC1_RX = 3'h5;
    localparam logic [2:0] SRC_SC2_RX = 3'h6;
    localparam logic [2:0] SRC_TICK = 3'h7;

    // Command codes
    localparam logic [7:0] CMD_DCHAN_REQUEST_CLASS_ONE = 8'h0E;
    localparam logic [7:0] CMD_DCHAN_REQUEST_CLASS_TWO = 8'h0F;
    localparam logic [7:0] CMD_DCHAN_ACCESS_ON = 8'h90;
    localparam logic [7:0] CMD_DCHAN_ACCESS_OFF = 8'h91;
    localparam logic [7:0] CMD_ECHO_FORCE_ZERO = 8'h96;
    localparam logic [7:0] CMD_ECHO_FORCE_INVERTED = 8'h97;
    localparam logic [7:0] CMD_ECHO_NORMAL = 8'h9C;
    localparam logic [7:0] CMD_MSG_END_IRQ_ON = 8'h10;
    localparam logic [7:0] CMD_MSG_END_IRQ_OFF = 8'h11;
    localparam logic [7:0] CMD_SC1_MESSAGING_ON = 8'h12;
    localparam logic [7:0] CMD_SC1_MESSAGING_OFF = 8'h13;
    localparam logic [7:0] CMD_TICK_5MS_ON = 8'h22;
    localparam logic [7:0] CMD_TICK_5MS_OFF = 8'h23;
    localparam logic [7:0] CMD_TICK_30MS_ON = 8'h24;
    localparam logic [7:0] CMD_TICK_30MS_OFF = 8'h25;
    localparam logic [7:0] CMD_SC2_MESSAGING_ON = 8'h26;
    localparam logic [7:0] CMD_SC2_MESSAGING_OFF = 8'h27;
    localparam logic [7:0] CMD_RX_VALIDATION_ON = 8'h28;
    localparam logic [7:0] CMD_RX_VALIDATION_OFF = 8'h29;
    localparam logic [7:0] CMD_BCHAN1_ON = 8'h14;
    localparam logic [7:0] CMD_BCHAN1_OFF = 8'h15;
    localparam logic [7:0] CMD_BCHAN2_ON = 8'h16;
    localparam logic [7:0] CMD_BCHAN2_OFF = 8'h17;
    localparam logic [7:0] CMD_BCHAN1_LOOP_TO_LINE = 8'h18;
    localparam logic [7:0] CMD_LOOPS_CLEAR = 8'h1B;
    localparam logic [7:0] CMD_BCHAN1_LOOP_TO_SYSTEM = 8'h1C;
    localparam logic [7:0] CMD_BCHAN2_LOOP_TO_SYSTEM = 8'h1D;
    localparam logic [3:0] NIB_SC1_TX_LOW_PRIORITY_WRITE = 4'h3;
    localparam logic [3:0] NIB_SC1_TX_HIGH_PRIORITY_WRITE = 4'h4;
    localparam logic [3:0] NIB_SC2_TX_WRITE = 4'h5;

    // Status codes
    localparam logic [7:0] ST_NO_CHANGE_STATUS = 8'h00;
    localparam logic [7:0] ST_FAR_END = 8'h02;
    localparam logic [7:0] ST_TICK = 8'h04;
    localparam logic [7:0] ST_MSG_END = 8'h06;
    localparam logic [7:0] ST_ACT_DONE = 8'h0C;
    localparam logic [7:0] ST_FRAME_LOSS = 8'h0E;
    localparam logic [7:0] ST_DEACT = 8'h0F;
    localparam logic [3:0] ST_SC1_RX_NIB = 4'h3;
    localparam logic [3:0] ST_SC2_RX_NIB = 4'h5;

    typedef enum logic [1:0] {
        ECHO_NORMAL = 2'b00,
        ECHO_ZERO = 2'b01,
        ECHO_INVERTED = 2'b10
    } ctp_echo_t;

    typedef struct packed {
        logic dchan_access_on;
        ctp_echo_t echo;
        logic msg_end_irq_on;
        logic sc1_messaging_on;
        logic sc2_messaging_on;
        logic tick_5ms_on;
        logic tick_30ms_on;
        logic rx_validation_on;
        logic bchan1_on;
        logic bchan2_on;
        logic bchan1_loop_to_line;
        logic bchan1_loop_to_system;
        logic bchan2_loop_to_system;
        logic [3:0] sc1_tx_low;
        logic [3:0] sc1_tx_high;
        logic [3:0] sc2_tx;
    } ctp_cfg_t;

    localparam ctp_cfg_t CFG_RESET = '{echo: ECHO_NORMAL,
        msg_end_irq_on: 1'b1, default: '0};

    typedef struct packed {
        logic dchan_request_class_one;
        logic dchan_request_class_two;
        logic sc1_tx_low_priority_write;
        logic sc1_tx_high_priority_write;
        logic sc2_tx_write;
    } ctp_stb_t;

    typedef struct packed {
        logic far_end_detect;
        logic frame_loss_event;
        logic activation_done_event;
        logic deactivation_event;
        logic tx_message_end_event;
        logic sc1_rx_buffer_event;
        logic sc2_rx_buffer_event;
        logic tick_5ms;
        logic tick_30ms;
        logic [3:0] sc1_bits;
        logic [3:0] sc2_bits;
    } ctp_evt_t;

endpackage : ctp_pkg

// ===== design/ctp_ctrl_port.sv
// Overview of operation
// [RQ1] Port works identically in powered-down and powered-up states.
// [RQ2] Each transaction swaps one command byte in for one status byte out.
// [RQ3] Eight clocks with select low; sample rising, shift status on falling.
// [RQ4] Interrupt driven low and latched when any status condition changes.
// [RQ5] Interrupt released on the first rising shift clock after select falls.
// [RQ6] Further sources queue; interrupt reasserted only while select is high.
// [RQ7] Host sends a harmless no-operation command whenever it reads status.
// [RQ8] One latch per source; pending events reported round-robin, no priority.
// [RQ9] Repeated unread event overwrites the earlier; newer message bits replace.
// [RQ10] Deactivation event clears every other pending interrupt.
// [RQ11] Far-end detect valid only powered down; power commands reset it.
// [RQ12] 0x0E requests class one D access, 0x0F class two.
// [RQ13] 0x90 enables D-channel contention, 0x91 disables it.
// [RQ14] 0x96 forces echo zero, 0x97 inverted D, 0x9C normal echo.
// [RQ15] 0x10 enables message-end interrupt (default), 0x11 disables it.
// [RQ16] 0x12 enables SC1/Q messaging and interrupt, 0x13 disables both.
// [RQ17] 5 ms and 30 ms ticks separately enabled; 0x23, 0x25 disable.
// [RQ18] SC2 messaging and interrupt enable command; 0x27 disables both.
// [RQ19] 0x28 enables received message validation, 0x29 disables it.
// [RQ20] Nibbles 3, 4, 5 write SC1 low, SC1 high, SC2 message bits.
// [RQ21] 0x14/0x15 switch B1, 0x16/0x17 switch B2 on and off.
// [RQ22] 0x18 loops B1 to line; 0x1C/0x1D to system; 0x1B clears.
// [RQ23] Enable codes 0x22, 0x24, 0x26 for 5 ms, 30 ms, SC2.
// [RQ24] After reset all option defaults apply: channels, loops, messaging off.
// [RQ25] D access defaults off in slave mode, on in master mode.
// [RQ26] With nothing pending, exchanges return no-change status, no interrupt.
`timescale 1ns/100ps
`default_nettype none
module ctp_ctrl_port (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic CTRL_SHIFT_CLOCK,
    input wire logic SEL_N,
    input wire logic COMMAND_IN,
    output logic STATUS_OUT,
    output logic STATUS_OUT_OE,
    output logic IRQ_N_OUT,
    output logic IRQ_N_OE,
    input wire ctp_pkg::ctp_evt_t EVT,
    input wire logic POWER_UP_CMD,
    input wire logic POWER_DOWN_CMD,
    input wire logic TERMINAL_MASTER_MODE,
    output ctp_pkg::ctp_cfg_t CFG,
    output ctp_pkg::ctp_stb_t STB,
    output logic POWERED_DOWN
);

    // Link side, clocked by the host's shift clock
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_in_r;
    logic [7:0] cmd_hold_r;
    logic cmd_tgl_r;
    logic rise_seen_r;
    logic out_bit_r;
    logic fell_r;
    localparam int NSRC_W = ctp_pkg::NSRC;
    // Core side
    logic sel_s1_r, sel_s2_r, rise_s1_r, rise_s2_r;
    logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
    logic cmd_evt, idle;
    logic init_r, powered_down_r, irq_r, rep_vld_r;
    logic [2:0] rep_idx_r, rr_r, sel_idx;
    logic sel_vld;
    logic [7:0] stat_word_r;
    logic [NSRC_W-1:0] pend_r, sets, clrs;
    logic [3:0] sc1_bits_r, sc2_bits_r;
    ctp_pkg::ctp_cfg_t cfg_r;
    ctp_pkg::ctp_stb_t stb_r;

    function automatic logic [7:0] stat_code(input logic [2:0] idx,
            input logic [3:0] m1, input logic [3:0] m2);
        case (idx)
            ctp_pkg::SRC_FAR_END: stat_code = ctp_pkg::ST_FAR_END;
            ctp_pkg::SRC_FRAME_LOSS: stat_code = ctp_pkg::ST_FRAME_LOSS;
            ctp_pkg::SRC_ACT_DONE: stat_code = ctp_pkg::ST_ACT_DONE;
            ctp_pkg::SRC_DEACT: stat_code = ctp_pkg::ST_DEACT;
            ctp_pkg::SRC_MSG_END: stat_code = ctp_pkg::ST_MSG_END;
            ctp_pkg::SRC_SC1_RX: stat_code = {ctp_pkg::ST_SC1_RX_NIB, m1};
            ctp_pkg::SRC_SC2_RX: stat_code = {ctp_pkg::ST_SC2_RX_NIB, m2};
            ctp_pkg::SRC_TICK: stat_code = ctp_pkg::ST_TICK;
            default: stat_code = ctp_pkg::ST_NO_CHANGE_STATUS;
        endcase
    endfunction : stat_code

    // Bit counter, cleared by select high while the clock stands still
    always_ff @(posedge CTRL_SHIFT_CLOCK or posedge SEL_N) begin
        if (SEL_N) begin
            bit_cnt_r <= 4'h0;
            rise_seen_r <= 1'b0;
        end else begin
            rise_seen_r <= 1'b1; // RQ5
            if (bit_cnt_r != ctp_pkg::BITS_PER_FRAME) begin
                bit_cnt_r <= bit_cnt_r + 4'h1; // RQ3
            end
        end
    end

    // Command sampled on rising edges
    always_ff @(posedge CTRL_SHIFT_CLOCK) begin
        if (!SEL_N && bit_cnt_r != ctp_pkg::BITS_PER_FRAME) begin
            shift_in_r <= {shift_in_r[6:0], COMMAND_IN}; // RQ3
        end
    end

    // Whole byte handed over with a toggle
    always_ff @(posedge CTRL_SHIFT_CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmd_hold_r <= 8'hFF;
            cmd_tgl_r <= 1'b0;
        end else if (!SEL_N && bit_cnt_r == ctp_pkg::LAST_BIT_CNT) begin
            cmd_hold_r <= {shift_in_r[6:0], COMMAND_IN}; // RQ2
            cmd_tgl_r <= ~cmd_tgl_r;
        end
    end

    // Status shifted out on falling edges, MSB first
    always_ff @(negedge CTRL_SHIFT_CLOCK or posedge SEL_N) begin
        if (SEL_N) begin
            out_bit_r <= 1'b0;
            fell_r <= 1'b0;
        end else if (bit_cnt_r != 4'h0 && bit_cnt_r[3] == 1'b0) begin
            out_bit_r <= stat_word_r[~bit_cnt_r[2:0]]; // RQ3
            fell_r <= 1'b1;
        end
    end

    // Top bit stands until the first falling edge
    assign STATUS_OUT = fell_r ? out_bit_r : stat_word_r[7]; // RQ3
    assign STATUS_OUT_OE = ~SEL_N;
    assign IRQ_N_OUT = 1'b0;
    assign IRQ_N_OE = irq_r & ~rise_seen_r; // RQ5
    assign CFG = cfg_r;
    assign STB = stb_r;
    assign POWERED_DOWN = powered_down_r;

    // Synchronisers into the core clock
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sel_s1_r <= 1'b1;
            sel_s2_r <= 1'b1;
            rise_s1_r <= 1'b0;
            rise_s2_r <= 1'b0;
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
        end else begin
            sel_s1_r <= SEL_N;
            sel_s2_r <= sel_s1_r;
            rise_s1_r <= rise_seen_r;
            rise_s2_r <= rise_s1_r;
            tgl_s1_r <= cmd_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end

    assign cmd_evt = tgl_s2_r ^ tgl_s3_r;
    assign idle = sel_s2_r & ~rise_s2_r & ~cmd_evt;

    // Command decoder; all options take effect regardless of power state
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            cfg_r <= ctp_pkg::CFG_RESET; // RQ24
            init_r <= 1'b1;
        end else begin
            init_r <= 1'b0;
            if (init_r) begin
                cfg_r.dchan_access_on <= TERMINAL_MASTER_MODE; // RQ25
            end else if (cmd_evt) begin // RQ1
                case (cmd_hold_r)
                    ctp_pkg::CMD_DCHAN_ACCESS_ON: cfg_r.dchan_access_on <= 1'b1; // RQ13
                    ctp_pkg::CMD_DCHAN_ACCESS_OFF: cfg_r.dchan_access_on <= 1'b0; // RQ13
                    ctp_pkg::CMD_ECHO_FORCE_ZERO: cfg_r.echo <= ctp_pkg::ECHO_ZERO; // RQ14
                    ctp_pkg::CMD_ECHO_FORCE_INVERTED: begin
                        cfg_r.echo <= ctp_pkg::ECHO_INVERTED; // RQ14
                    end
                    ctp_pkg::CMD_ECHO_NORMAL: cfg_r.echo <= ctp_pkg::ECHO_NORMAL; // RQ14
                    ctp_pkg::CMD_MSG_END_IRQ_ON: cfg_r.msg_end_irq_on <= 1'b1; // RQ15
                    ctp_pkg::CMD_MSG_END_IRQ_OFF: cfg_r.msg_end_irq_on <= 1'b0; // RQ15
                    ctp_pkg::CMD_SC1_MESSAGING_ON: cfg_r.sc1_messaging_on <= 1'b1; // RQ16
                    ctp_pkg::CMD_SC1_MESSAGING_OFF: cfg_r.sc1_messaging_on <= 1'b0; // RQ16
                    ctp_pkg::CMD_TICK_5MS_ON: cfg_r.tick_5ms_on <= 1'b1; // RQ23
                    ctp_pkg::CMD_TICK_5MS_OFF: cfg_r.tick_5ms_on <= 1'b0; // RQ17
                    ctp_pkg::CMD_TICK_30MS_ON: cfg_r.tick_30ms_on <= 1'b1; // RQ23
                    ctp_pkg::CMD_TICK_30MS_OFF: cfg_r.tick_30ms_on <= 1'b0; // RQ17
                    ctp_pkg::CMD_SC2_MESSAGING_ON: cfg_r.sc2_messaging_on <= 1'b1; // RQ18
                    ctp_pkg::CMD_SC2_MESSAGING_OFF: cfg_r.sc2_messaging_on <= 1'b0; // RQ18
                    ctp_pkg::CMD_RX_VALIDATION_ON: cfg_r.rx_validation_on <= 1'b1; // RQ19
                    ctp_pkg::CMD_RX_VALIDATION_OFF: cfg_r.rx_validation_on <= 1'b0; // RQ19
                    ctp_pkg::CMD_BCHAN1_ON: cfg_r.bchan1_on <= 1'b1; // RQ21
                    ctp_pkg::CMD_BCHAN1_OFF: cfg_r.bchan1_on <= 1'b0; // RQ21
                    ctp_pkg::CMD_BCHAN2_ON: cfg_r.bchan2_on <= 1'b1; // RQ21
                    ctp_pkg::CMD_BCHAN2_OFF: cfg_r.bchan2_on <= 1'b0; // RQ21
                    ctp_pkg::CMD_BCHAN1_LOOP_TO_LINE: begin
                        cfg_r.bchan1_loop_to_line <= 1'b1; // RQ22
                    end
                    ctp_pkg::CMD_BCHAN1_LOOP_TO_SYSTEM: begin
                        cfg_r.bchan1_loop_to_system <= 1'b1; // RQ22
                    end
                    ctp_pkg::CMD_BCHAN2_LOOP_TO_SYSTEM: begin
                        cfg_r.bchan2_loop_to_system <= 1'b1; // RQ22
                    end
                    ctp_pkg::CMD_LOOPS_CLEAR: begin
                        cfg_r.bchan1_loop_to_line <= 1'b0; // RQ22
                        cfg_r.bchan1_loop_to_system <= 1'b0;
                        cfg_r.bchan2_loop_to_system <= 1'b0;
                    end
                    default: begin
                        case (cmd_hold_r[7:4])
                            ctp_pkg::NIB_SC1_TX_LOW_PRIORITY_WRITE: begin
                                cfg_r.sc1_tx_low <= cmd_hold_r[3:0]; // RQ20
                            end
                            ctp_pkg::NIB_SC1_TX_HIGH_PRIORITY_WRITE: begin
                                cfg_r.sc1_tx_high <= cmd_hold_r[3:0]; // RQ20
                            end
                            ctp_pkg::NIB_SC2_TX_WRITE: begin
                                cfg_r.sc2_tx <= cmd_hold_r[3:0]; // RQ20
                            end
                            default: begin
                            end
                        endcase
                    end
                endcase
            end
        end
    end

    // One-cycle strobes for requests and message writes
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            stb_r <= '0;
        end else begin
            stb_r.dchan_request_class_one <= cmd_evt
                && cmd_hold_r == ctp_pkg::CMD_DCHAN_REQUEST_CLASS_ONE; // RQ12
            stb_r.dchan_request_class_two <= cmd_evt
                && cmd_hold_r == ctp_pkg::CMD_DCHAN_REQUEST_CLASS_TWO; // RQ12
            stb_r.sc1_tx_low_priority_write <= cmd_evt && cmd_hold_r[7:4]
                == ctp_pkg::NIB_SC1_TX_LOW_PRIORITY_WRITE; // RQ20
            stb_r.sc1_tx_high_priority_write <= cmd_evt && cmd_hold_r[7:4]
                == ctp_pkg::NIB_SC1_TX_HIGH_PRIORITY_WRITE; // RQ20
            stb_r.sc2_tx_write <= cmd_evt
                && cmd_hold_r[7:4] == ctp_pkg::NIB_SC2_TX_WRITE; // RQ20
        end
    end

    // Event set and consume vectors
    always_comb begin
        sets = '0;
        sets[ctp_pkg::SRC_FAR_END] = EVT.far_end_detect & powered_down_r
            & ~POWER_UP_CMD; // RQ11
        sets[ctp_pkg::SRC_FRAME_LOSS] = EVT.frame_loss_event;
        sets[ctp_pkg::SRC_ACT_DONE] = EVT.activation_done_event;
        sets[ctp_pkg::SRC_DEACT] = EVT.deactivation_event;
        sets[ctp_pkg::SRC_MSG_END] = EVT.tx_message_end_event
            & cfg_r.msg_end_irq_on; // RQ15
        sets[ctp_pkg::SRC_SC1_RX] = EVT.sc1_rx_buffer_event
            & cfg_r.sc1_messaging_on; // RQ16
        sets[ctp_pkg::SRC_SC2_RX] = EVT.sc2_rx_buffer_event
            & cfg_r.sc2_messaging_on; // RQ18
        sets[ctp_pkg::SRC_TICK] = (EVT.tick_5ms & cfg_r.tick_5ms_on)
            | (EVT.tick_30ms & cfg_r.tick_30ms_on); // RQ17
        clrs = '0;
        if (cmd_evt && rep_vld_r) begin
            clrs[rep_idx_r] = 1'b1;
        end
        if (POWER_UP_CMD || POWER_DOWN_CMD) begin
            clrs[ctp_pkg::SRC_FAR_END] = 1'b1; // RQ11
        end
    end

    // Per-source latches; a new event wins over its clear
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            pend_r <= '0;
        end else if (sets[ctp_pkg::SRC_DEACT]) begin
            pend_r <= '0; // RQ10
            pend_r[ctp_pkg::SRC_DEACT] <= 1'b1;
        end else begin
            pend_r <= (pend_r & ~clrs) | sets; // RQ8 RQ9
        end
    end

    // Latest message bits overwrite unread ones
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            sc1_bits_r <= 4'h0;
            sc2_bits_r <= 4'h0;
        end else begin
            if (sets[ctp_pkg::SRC_SC1_RX]) begin
                sc1_bits_r <= EVT.sc1_bits; // RQ9
            end
            if (sets[ctp_pkg::SRC_SC2_RX]) begin
                sc2_bits_r <= EVT.sc2_bits; // RQ9
            end
        end
    end

    // Power state for far-end detection
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            powered_down_r <= 1'b1;
        end else if (POWER_UP_CMD) begin
            powered_down_r <= 1'b0; // RQ11
        end else if (POWER_DOWN_CMD) begin
            powered_down_r <= 1'b1; // RQ11
        end
    end

    // Circular scan starting at the round-robin pointer
    always_comb begin
        logic [2:0] j;
        j = rr_r;
        sel_vld = 1'b0;
        sel_idx = rr_r;
        for (int k = 0; k < NSRC_W; k++) begin
            j = rr_r + 3'(k);
            if (!sel_vld && pend_r[j]) begin
                sel_vld = 1'b1; // RQ8
                sel_idx = j;
            end
        end
    end

    // Status word and interrupt latch
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            stat_word_r <= ctp_pkg::ST_NO_CHANGE_STATUS;
            rep_idx_r <= 3'h0;
            rep_vld_r <= 1'b0;
            irq_r <= 1'b0;
            rr_r <= 3'h0;
        end else begin
            // Rescanned while pending so newer events show
            if (idle) begin
                stat_word_r <= sel_vld
                    ? stat_code(sel_idx, sc1_bits_r, sc2_bits_r)
                    : ctp_pkg::ST_NO_CHANGE_STATUS; // RQ26
                rep_idx_r <= sel_idx;
                rep_vld_r <= sel_vld;
                irq_r <= sel_vld; // RQ4 RQ6
            end else if (rise_s2_r) begin
                irq_r <= 1'b0; // RQ5
            end
            if (cmd_evt && rep_vld_r) begin
                rep_vld_r <= 1'b0;
                rr_r <= rep_idx_r + 3'h1; // RQ8
            end
        end
    end

    // Checks
    property p_irq_sel_high;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        $rose(irq_r) |-> $past(sel_s2_r) && $past(!rise_s2_r);
    endproperty
    a_irq_sel_high: assert property (p_irq_sel_high) // RQ6
        else $error("interrupt raised while select low");

    property p_release;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        rise_s2_r && !idle |=> !irq_r;
    endproperty
    a_release: assert property (p_release) // RQ5
        else $error("interrupt not released after first shift edge");

    property p_no_change;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        idle && !irq_r && pend_r == '0 |=> stat_word_r == 8'h00 && !irq_r;
    endproperty
    a_no_change: assert property (p_no_change) // RQ26
        else $error("no-change status expected without interrupt");

    property p_deact_clears;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        sets[ctp_pkg::SRC_DEACT] |=> pend_r == 8'h08;
    endproperty
    a_deact_clears: assert property (p_deact_clears) // RQ10
        else $error("deactivation did not clear pending events");

    property p_mfr_overwrite;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        sets[ctp_pkg::SRC_SC1_RX] |=> sc1_bits_r == $past(EVT.sc1_bits);
    endproperty
    a_mfr_overwrite: assert property (p_mfr_overwrite) // RQ9
        else $error("newer message bits did not overwrite");

    property p_power_up;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        POWER_UP_CMD |=> !powered_down_r && !pend_r[0];
    endproperty
    a_power_up: assert property (p_power_up) // RQ11
        else $error("power-up did not reset far-end detect");

    property p_dreq;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        cmd_evt && cmd_hold_r == 8'h0E |=> STB.dchan_request_class_one
            ##1 !STB.dchan_request_class_one;
    endproperty
    a_dreq: assert property (p_dreq) // RQ12
        else $error("class one request strobe wrong");

    property p_echo;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        cmd_evt && !init_r && cmd_hold_r == 8'h96
            |=> CFG.echo == ctp_pkg::ECHO_ZERO;
    endproperty
    a_echo: assert property (p_echo) // RQ14
        else $error("echo not forced to zero");

    property p_rr;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        cmd_evt && rep_vld_r |=> rr_r == $past(rep_idx_r) + 3'h1;
    endproperty
    a_rr: assert property (p_rr) // RQ8
        else $error("round-robin pointer did not advance");

    property p_byte;
        @(negedge CTRL_SHIFT_CLOCK) disable iff (SEL_N || SYS_RST)
        bit_cnt_r == 4'h8 |-> cmd_tgl_r != $past(cmd_tgl_r);
    endproperty
    a_byte: assert property (p_byte) // RQ3
        else $error("byte not handed over on eighth edge");

    c_irq: cover property (@(posedge CORE_CLK) $rose(irq_r));
    c_deact: cover property (@(posedge CORE_CLK) sets[ctp_pkg::SRC_DEACT]
        && pend_r != '0);
    c_two_pending: cover property (@(posedge CORE_CLK)
        cmd_evt && rep_vld_r && (pend_r & ~clrs) != '0);

endmodule : ctp_ctrl_port
`default_nettype wire

// ===== tb/ctp_host.sv
`timescale 1ns/100ps
`default_nettype none
module ctp_host (
    output logic SCK = 1'h0,
    output logic SEL_N,
    output logic CMD = 1'h1,
    input wire logic STATUS
);
    // One rising select edge clears the link counters
    initial #1 SEL_N = 1'h1;
    task automatic xfer(input logic [7:0] c, output logic [7:0] s);
        SEL_N = 1'h0;
        for (int i = 7; i >= 0; i--) begin
            CMD = c[i];
            #7.5 SCK = 1'h1;
            s[i] = STATUS;
            #7.5 SCK = 1'h0;
        end
        #7.5 SEL_N = 1'h1;
        CMD = ~CMD;
    endtask : xfer
endmodule : ctp_host
`default_nettype wire

// ===== tb/tb_ctp_ctrl_port.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ctp_ctrl_port;
    logic clk = 1'h0;
    logic rst = 1'h0;
    logic power_up_cmd = 1'h0, power_down_cmd = 1'h0, tmm = 1'h1;
    ctp_pkg::ctp_evt_t evt = '0;
    ctp_pkg::ctp_cfg_t cfg, m;
    ctp_pkg::ctp_stb_t stb, stb_seen;
    logic sck, sel_n, cmd, sout, irq, pd, oe, iout;
    logic [7:0] st;
    logic [3:0] nib;
    int mismatches = 0;
    int checks_done = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) stb_seen <= stb_seen | stb;
    ctp_host ctp_host_inst (.SCK(sck), .SEL_N(sel_n), .CMD(cmd),
        .STATUS(sout));
    ctp_ctrl_port ctp_ctrl_port_inst (.CORE_CLK(clk), .SYS_RST(rst),
        .CTRL_SHIFT_CLOCK(sck), .SEL_N(sel_n), .COMMAND_IN(cmd),
        .STATUS_OUT(sout), .STATUS_OUT_OE(oe), .IRQ_N_OUT(iout),
        .IRQ_N_OE(irq), .EVT(evt), .POWER_UP_CMD(power_up_cmd),
        .POWER_DOWN_CMD(power_down_cmd), .CFG(cfg), .TERMINAL_MASTER_MODE(tmm),
        .STB(stb), .POWERED_DOWN(pd));
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %0h got %0h", n, e, g);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic pulse(input ctp_pkg::ctp_evt_t v);
        @(negedge clk) evt = v;
        @(negedge clk) evt = '0;
    endtask : pulse
    task automatic rd(input logic [7:0] e);
        repeat (10) @(negedge clk);
        chk("irq", e != 8'h00, irq);
        @(negedge clk) #1.3 ctp_host_inst.xfer(8'hFF, st);
        chk("status", e, st);
        repeat (8) @(negedge clk);
        chk("pins", 2'h0, {oe, iout});
        $display("read done %h", e);
    endtask : rd
    task automatic wr(input logic [7:0] c);
        ctp_pkg::ctp_stb_t es;
        casez (c)
            8'h14, 8'h15: m.bchan1_on = ~c[0];
            8'h16, 8'h17: m.bchan2_on = ~c[0];
            8'h18: m.bchan1_loop_to_line = 1'h1;
            8'h1C: m.bchan1_loop_to_system = 1'h1;
            8'h1D: m.bchan2_loop_to_system = 1'h1;
            8'h1B: {m.bchan1_loop_to_line, m.bchan1_loop_to_system,
                m.bchan2_loop_to_system} = '0;
            8'h28, 8'h29: m.rx_validation_on = ~c[0];
            8'h12, 8'h13: m.sc1_messaging_on = ~c[0];
            8'h26, 8'h27: m.sc2_messaging_on = ~c[0];
            8'h22, 8'h23: m.tick_5ms_on = ~c[0];
            8'h24, 8'h25: m.tick_30ms_on = ~c[0];
            8'h96: m.echo = ctp_pkg::ECHO_ZERO;
            8'h97: m.echo = ctp_pkg::ECHO_INVERTED;
            8'h9C: m.echo = ctp_pkg::ECHO_NORMAL;
            8'h10, 8'h11: m.msg_end_irq_on = ~c[0];
            8'h90, 8'h91: m.dchan_access_on = ~c[0];
            8'h3?: m.sc1_tx_low = c[3:0];
            8'h4?: m.sc1_tx_high = c[3:0];
            8'h5?: m.sc2_tx = c[3:0];
            default: ;
        endcase
        es = {c == 8'h0E, c == 8'h0F, c[7:4] == 4'h3, c[7:4] == 4'h4,
            c[7:4] == 4'h5};
        stb_seen = '0;
        @(negedge clk) #1.3 ctp_host_inst.xfer(c, st);
        repeat (8) @(negedge clk);
        chk("noc", 8'h00, st);
        chk("cfg", m, cfg);
        chk("stb", es, stb_seen);
        $display("command done %h", c);
    endtask : wr
    initial begin
        #200000;
        mismatches++;
        results();
    end
    initial begin
        logic [7:0] cmds[$] = '{8'h14, 8'h16, 8'h15, 8'h17, 8'h14, 8'h16,
            8'h18, 8'h1C, 8'h1D, 8'h1B, 8'h28, 8'h29, 8'h28, 8'h13, 8'h12,
            8'h26, 8'h27, 8'h22, 8'h23, 8'h22, 8'h24, 8'h25, 8'h96, 8'h97,
            8'h9C, 8'h11, 8'h10, 8'h11, 8'h91, 8'h90, 8'h91, 8'h0E, 8'h0F};
        void'($urandom(32'h5157));
        #1 rst = 1'h1;
        repeat (5) @(negedge clk);
        rst = 1'h0;
        repeat (4) @(negedge clk);
        m = ctp_pkg::CFG_RESET;
        m.dchan_access_on = 1'h1;
        chk("cfg", m, cfg);
        foreach (cmds[i]) wr(cmds[i]);
        for (int k = 3; k < 6; k++) wr({k[3:0], 4'($urandom)});
        pulse(17'h10000);
        rd(ctp_pkg::ST_FAR_END);
        pulse(17'h04000);
        rd(ctp_pkg::ST_ACT_DONE);
        nib = 4'($urandom);
        pulse({9'h008, 4'hA, 4'h0});
        pulse(17'h08000);
        pulse({9'h008, nib, 4'h0});
        rd({4'h3, nib});
        rd(ctp_pkg::ST_FRAME_LOSS);
        pulse(17'h00200);
        rd(ctp_pkg::ST_TICK);
        pulse(17'h01400);
        rd(8'h00);
        pulse(17'h08000);
        pulse(17'h02000);
        rd(ctp_pkg::ST_DEACT);
        rd(8'h00);
        @(negedge clk) power_up_cmd = 1'h1;
        @(negedge clk) power_up_cmd = 1'h0;
        pulse(17'h10000);
        rd(8'h00);
        chk("pd", 1'h0, pd);
        @(negedge clk) power_down_cmd = 1'h1;
        @(negedge clk) power_down_cmd = 1'h0;
        chk("pd", 1'h1, pd);
        pulse(17'h10000);
        rd(ctp_pkg::ST_FAR_END);
        tmm = 1'h0;
        rst = 1'h1;
        repeat (5) @(negedge clk);
        rst = 1'h0;
        repeat (4) @(negedge clk);
        m = ctp_pkg::CFG_RESET;
        chk("cfg", m, cfg);
        results();
    end
endmodule : tb_ctp_ctrl_port
`default_nettype wire
